/* serial_link_config_regs.sv */
// serial link configuration register bank with multiframe phase alignment
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "serial_link_defs.svh"
module serial_link_config_regs
(
    input  wire logic                      ref_clk,
    input  wire logic                      rst,
    input  wire logic [`REG_ADDR_W-1:0]    reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [7:0]                reg_rdata,
    input  wire logic                      sysref,
    output serial_link_pkg::link_test_t    test_mode,
    output logic                           test_active,
    output logic      [7:0]                test_octet,
    output logic      [7:0]                device_id,
    output logic      [3:0]                bank_id,
    output serial_link_pkg::lane_ids_t     lane_id,
    output logic                           scrambler_en,
    output logic      [4:0]                lane_count_code,
    output logic      [2:0]                lanes_active,
    output logic      [8:0]                octets_per_frame,
    output logic      [5:0]                frames_per_multiframe,
    output logic      [4:0]                mf_phase,
    output logic                           mf_start,
    output logic                           cfg_invalid
);
    logic [4:0] phase_ofs_r;
    logic [7:0] octets_per_frame_minus_one;
    logic [4:0] frames_per_multiframe_minus_one;
    logic       sys_s1_r;
    logic       sys_s2_r;
    logic       sys_s3_r;
    logic [7:0] rdata_nxt;
    logic [14:0] fk_product;
    logic       wr_hit;

    mf_phase_if mf ();

    mf_phase_counter u_phase
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .mf      (mf.counter)
    );

    // the counter follows the multiframe length of the live setting
    assign mf.k_minus_one = frames_per_multiframe_minus_one;
    assign mf.load_value  = phase_ofs_r;
    assign mf.load        = sys_s2_r && !sys_s3_r;
    assign mf_phase       = mf.phase;
    assign mf_start       = mf.wrap;
    assign wr_hit         = reg_wr;

    // system reference is a pin: two stages before anything looks at it
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sys_s1_r <= 1'b0;
            sys_s2_r <= 1'b0;
            sys_s3_r <= 1'b0;
        end
        else
        begin
            sys_s1_r <= sysref;
            sys_s2_r <= sys_s1_r;
            sys_s3_r <= sys_s2_r;
        end
    end

    // test selector; reserved codes are stored but send no pattern
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            test_mode <= serial_link_pkg::link_test_t'(`RST_LL_TEST);
        else if (wr_hit && reg_addr == `A_LL_TEST)
            test_mode <= serial_link_pkg::link_test_t'(reg_wdata[2:0]);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            test_active <= 1'b0;
            test_octet  <= 8'h00;
        end
        else
        begin
            case (test_mode)
                serial_link_pkg::tm_d21_5:
                begin
                    test_active <= 1'b1;
                    test_octet  <= `D21_5_OCTET;
                end
                serial_link_pkg::tm_rpat,
                serial_link_pkg::tm_jspat,
                serial_link_pkg::tm_jtspat:
                begin
                    test_active <= 1'b1;
                    test_octet  <= 8'h00;
                end
                default:
                begin
                    test_active <= 1'b0;
                    test_octet  <= 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            phase_ofs_r <= `RST_PHASE_OFS;
        else if (wr_hit && reg_addr == `A_PHASE_OFS)
            phase_ofs_r <= reg_wdata[4:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            device_id <= `RST_DEV_ID;
        else if (wr_hit && reg_addr == `A_DEV_ID)
            device_id <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            bank_id <= `RST_BANK_ID;
        else if (wr_hit && reg_addr == `A_BANK_ID)
            bank_id <= reg_wdata[3:0];
    end

    // lane identifiers, one independent field per lane
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            lane_id[0] <= `RST_LANE0_ID;
            lane_id[1] <= `RST_LANE1_ID;
            lane_id[2] <= `RST_LANE2_ID;
            lane_id[3] <= `RST_LANE3_ID;
        end
        else if (wr_hit)
        begin
            case (reg_addr)
                `A_LANE0_ID: lane_id[0] <= reg_wdata[4:0];
                `A_LANE1_ID: lane_id[1] <= reg_wdata[4:0];
                `A_LANE2_ID: lane_id[2] <= reg_wdata[4:0];
                `A_LANE3_ID: lane_id[3] <= reg_wdata[4:0];
                default:     lane_id    <= lane_id;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            scrambler_en    <= `RST_SCR;
            lane_count_code <= `RST_LANES;
        end
        else if (wr_hit && reg_addr == `A_SCR_LANES)
        begin
            scrambler_en    <= reg_wdata[`SCR_BIT];
            lane_count_code <= reg_wdata[4:0];
        end
    end

    // unlisted lane codes keep the previous lane count rather than guess
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            lanes_active <= 3'h4;
        else
        begin
            case (lane_count_code)
                `LANES_ONE:  lanes_active <= 3'h1;
                `LANES_TWO:  lanes_active <= 3'h2;
                `LANES_FOUR: lanes_active <= 3'h4;
                default:     lanes_active <= lanes_active;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            octets_per_frame_minus_one <= `RST_OCT_FRAME;
        else if (wr_hit && reg_addr == `A_OCT_FRAME)
            octets_per_frame_minus_one <= reg_wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            frames_per_multiframe_minus_one <= `RST_FRM_MF;
        else if (wr_hit && reg_addr == `A_FRM_MF)
            frames_per_multiframe_minus_one <= reg_wdata[4:0];
    end

    // only the low two bits of F and K decide divisibility by four
    assign fk_product = 15'(octets_per_frame_minus_one + 9'h001)
                      * 15'(frames_per_multiframe_minus_one + 6'h01);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            octets_per_frame      <= 9'h001;
            frames_per_multiframe <= 6'h20;
            cfg_invalid           <= 1'b0;
        end
        else
        begin
            octets_per_frame      <= {1'b0, octets_per_frame_minus_one} + 9'h001;
            frames_per_multiframe <= {1'b0, frames_per_multiframe_minus_one} + 6'h01;
            cfg_invalid           <= fk_product[1:0] != 2'h0;
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    always_comb
    begin
        case (reg_addr)
            `A_LL_TEST:   rdata_nxt = {5'h00, test_mode};
            `A_PHASE_OFS: rdata_nxt = {3'h0, phase_ofs_r};
            `A_STATUS:    rdata_nxt = {cfg_invalid, 2'h0, mf.phase};
            `A_DEV_ID:    rdata_nxt = device_id;
            `A_BANK_ID:   rdata_nxt = {4'h0, bank_id};
            `A_LANE0_ID:  rdata_nxt = {3'h0, lane_id[0]};
            `A_LANE1_ID:  rdata_nxt = {3'h0, lane_id[1]};
            `A_LANE2_ID:  rdata_nxt = {3'h0, lane_id[2]};
            `A_LANE3_ID:  rdata_nxt = {3'h0, lane_id[3]};
            `A_SCR_LANES: rdata_nxt = {scrambler_en, 2'h0, lane_count_code};
            `A_OCT_FRAME: rdata_nxt = octets_per_frame_minus_one;
            `A_FRM_MF:    rdata_nxt = {3'h0, frames_per_multiframe_minus_one};
            default:      rdata_nxt = 8'h00;
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_reset_values: assert property (
        $fell(rst) |-> test_mode == serial_link_pkg::tm_normal
            && lane_id[0] == 5'h00 && lane_id[1] == 5'h01
            && lane_id[2] == 5'h02 && lane_id[3] == 5'h03
            && scrambler_en && lane_count_code == 5'h03)
        else $error("reset values wrong");

    chk_d21_octet: assert property (
        test_mode == serial_link_pkg::tm_d21_5 |=> test_active && test_octet == 8'hB5)
        else $error("d21.5 stream not produced");

    chk_test_active: assert property (
        1'b1 |=> test_active == ($past(test_mode) inside
            {serial_link_pkg::tm_d21_5, serial_link_pkg::tm_rpat,
             serial_link_pkg::tm_jspat, serial_link_pkg::tm_jtspat}))
        else $error("test activity does not match selector");

    chk_phase_load: assert property (
        $rose(sys_s2_r) |=> mf_phase == $past(phase_ofs_r))
        else $error("phase counter not loaded from offset");

    chk_phase_sync: assert property (
        $rose(sysref) && !mf.load ##1 !sysref [*3] |-> $past(mf.load, 1) || mf.load)
        else $error("system reference edge not seen in time");

    chk_did_read: assert property (
        reg_rd && reg_addr == `A_DEV_ID |=> reg_rdata == $past(device_id))
        else $error("device identifier readback wrong");

    chk_bid_write: assert property (
        reg_wr && reg_addr == `A_BANK_ID |=> bank_id == $past(reg_wdata[3:0]))
        else $error("bank identifier not stored");

    chk_lid_write: assert property (
        reg_wr && reg_addr == `A_LANE2_ID |=> lane_id[2] == $past(reg_wdata[4:0])
            && lane_id[1] == $past(lane_id[1]) && lane_id[3] == $past(lane_id[3]))
        else $error("lane identifier write crossed lanes");

    chk_scr_write: assert property (
        reg_wr && reg_addr == `A_SCR_LANES |=> scrambler_en == $past(reg_wdata[7]))
        else $error("scrambler bit not taken from bit 7");

    chk_lane_decode: assert property (
        lane_count_code == 5'h03 ##1 lane_count_code == 5'h03 |-> lanes_active == 3'h4)
        else $error("four-lane code not decoded");

    chk_f_plus_one: assert property (
        1'b1 |=> octets_per_frame == {1'b0, $past(octets_per_frame_minus_one)} + 9'h001)
        else $error("octets per frame not field plus one");

    chk_k_plus_one: assert property (
        1'b1 |=> frames_per_multiframe
            == {1'b0, $past(frames_per_multiframe_minus_one)} + 6'h01
            && cfg_invalid == ($past(fk_product[1:0]) != 2'h0))
        else $error("frames per multiframe or divisibility flag wrong");

    cov_sysref_load: cover property ($rose(sys_s2_r) ##1 mf_phase != 5'h00);
    cov_d21_mode:    cover property (test_mode == serial_link_pkg::tm_d21_5 ##1 test_active);
    cov_bad_config:  cover property ($rose(cfg_invalid));
    cov_mf_wrap:     cover property (mf_start ##1 !mf_start);
endmodule

/* serial_link_defs.svh */
// offsets, field positions and reset values of the serial link configuration bank
`ifndef SERIAL_LINK_DEFS_SVH
`define SERIAL_LINK_DEFS_SVH

`define REG_ADDR_W      12
`define A_LL_TEST       12'h0577
`define A_PHASE_OFS     12'h0578
`define A_STATUS        12'h057A
`define A_DEV_ID        12'h0580
`define A_BANK_ID       12'h0581
`define A_LANE0_ID      12'h0583
`define A_LANE1_ID      12'h0584
`define A_LANE2_ID      12'h0585
`define A_LANE3_ID      12'h0586
`define A_SCR_LANES     12'h058B
`define A_OCT_FRAME     12'h058C
`define A_FRM_MF        12'h058D

`define SCR_BIT         7
`define STAT_BAD_BIT    7

`define RST_LL_TEST     3'h0
`define RST_PHASE_OFS   5'h00
`define RST_DEV_ID      8'h00
`define RST_BANK_ID     4'h0
`define RST_LANE0_ID    5'h00
`define RST_LANE1_ID    5'h01
`define RST_LANE2_ID    5'h02
`define RST_LANE3_ID    5'h03
`define RST_SCR         1'b1
`define RST_LANES       5'h03
`define RST_OCT_FRAME   8'h00
`define RST_FRM_MF      5'h1F

`define LANES_ONE       5'h00
`define LANES_TWO       5'h01
`define LANES_FOUR      5'h03
`define D21_5_OCTET     8'hB5

`endif

/* serial_link_pkg.sv */
// types shared by the serial link configuration bank
package serial_link_pkg;
    typedef logic [3:0][4:0] lane_ids_t;
    typedef enum logic [2:0]
    {
        tm_normal = 3'h0,
        tm_d21_5  = 3'h1,
        tm_rsv2   = 3'h2,
        tm_rsv3   = 3'h3,
        tm_rpat   = 3'h4,
        tm_jspat  = 3'h5,
        tm_jtspat = 3'h6,
        tm_rsv7   = 3'h7
    } link_test_t;
endpackage

/* mf_phase_if.sv */
// carrier between the register bank and the multiframe phase counter
`timescale 1ns/100ps
interface mf_phase_if;
    logic       load;
    logic [4:0] load_value;
    logic [4:0] k_minus_one;
    logic [4:0] phase;
    logic       wrap;
    modport ctrl
    (
        output load,
        output load_value,
        output k_minus_one,
        input  phase,
        input  wrap
    );
    modport counter
    (
        input  load,
        input  load_value,
        input  k_minus_one,
        output phase,
        output wrap
    );
endinterface

/* mf_phase_counter.sv */
// multiframe phase counter, one count per frame clock
`timescale 1ns/100ps
module mf_phase_counter
(
    input  wire logic   ref_clk,
    input  wire logic   rst,
    mf_phase_if.counter mf
);
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mf.phase <= 5'h00;
        else if (mf.load)
            mf.phase <= mf.load_value;
        else if (mf.phase >= mf.k_minus_one)
            mf.phase <= 5'h00;
        else
            mf.phase <= mf.phase + 5'h01;
    end

    // boundary marks the cycle the counter is back at zero by wrapping
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            mf.wrap <= 1'b0;
        else
            mf.wrap <= !mf.load && (mf.phase >= mf.k_minus_one);
    end
endmodule

/* link_rx_model.sv */
// serial link receiver stand-in: raises system reference and times multiframes
`timescale 1ns/100ps
module link_rx_model
(
    input  wire logic ref_clk,
    input  wire logic mf_start,
    output logic      sysref,
    output int        mf_period,
    output int        mf_count
);
    int cnt;
    initial
    begin
        sysref    = 1'b0;
        mf_period = 0;
        mf_count  = 0;
        cnt       = 0;
    end
    // held high for several cycles so that a level-based load would show as a stuck phase
    task automatic fire_sysref(input int hold);
        @(posedge ref_clk);
        sysref <= 1'b1;
        repeat (hold) @(posedge ref_clk);
        sysref <= 1'b0;
    endtask
    // the first period after a load may be short, so users look at the second one
    always @(posedge ref_clk)
    begin
        if (mf_start === 1'b1)
        begin
            mf_period <= cnt + 1;
            mf_count  <= mf_count + 1;
            cnt       <= 0;
        end
        else
            cnt <= cnt + 1;
    end
endmodule

/* serial_link_config_regs_tb_top.sv */
// self-checking bench for the serial link configuration bank
`timescale 1ns/100ps
`include "serial_link_defs.svh"
module serial_link_config_regs_tb_top;
    logic                           ref_clk = 1'b0, rst = 1'b1;
    logic [11:0]                    reg_addr = 12'h0000;
    logic [7:0]                     reg_wdata = 8'h00, reg_rdata, device_id, test_octet;
    logic                           reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
    logic                           sysref, test_active, scrambler_en, mf_start, cfg_invalid;
    serial_link_pkg::link_test_t    test_mode;
    serial_link_pkg::lane_ids_t     lane_id;
    logic [3:0]                     bank_id;
    logic [4:0]                     lane_count_code, mf_phase;
    logic [2:0]                     lanes_active;
    logic [8:0]                     octets_per_frame;
    logic [5:0]                     frames_per_multiframe;
    int                             fail_count = 0, checked = 0, mf_period, mf_count;
    logic [7:0]                     exp_q[$];
    logic [11:0] ra [0:10] = '{`A_LL_TEST, `A_PHASE_OFS, `A_DEV_ID, `A_BANK_ID, `A_LANE0_ID,
        `A_LANE1_ID, `A_LANE2_ID, `A_LANE3_ID, `A_SCR_LANES, `A_OCT_FRAME, `A_FRM_MF};
    logic [7:0]  rm [0:10] = '{8'h07, 8'h1f, 8'hff, 8'h0f, 8'h1f, 8'h1f, 8'h1f, 8'h1f,
        8'h9f, 8'hff, 8'h1f};
    logic [7:0]  rv [0:10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03,
        8'h83, 8'h00, 8'h1f};
    logic [7:0]  wv [0:10];
    int          fc [0:6] = '{0, 1, 2, 3, 5, 7, 15};
    int          lc [0:3] = '{0, 1, 2, 3};
    int          la [0:3] = '{1, 2, 2, 4};

    always #20 ref_clk = ~ref_clk;

    serial_link_config_regs serial_link_config_regs_i
    (
        .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sysref,
        .test_mode, .test_active, .test_octet, .device_id, .bank_id, .lane_id,
        .scrambler_en, .lane_count_code, .lanes_active, .octets_per_frame,
        .frames_per_multiframe, .mf_phase, .mf_start, .cfg_invalid
    );
    link_rx_model link_rx_model_i
    (
        .ref_clk, .mf_start, .sysref, .mf_period, .mf_count
    );

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask
    // derived outputs lag their register by one more edge
    task automatic settle;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge ref_clk)
        rd_d <= reg_rd;
    always @(negedge ref_clk)
        if (rd_d === 1'b1)
            cmp("reg_rdata", {24'h0, exp_q.pop_front()}, {24'h0, reg_rdata});

    initial
    begin
        #4_000_000;
        fail_count++;
        close_out();
    end

    initial
    begin
        int  off, n0, i, k, f;
        void'($urandom(32'h0000_f51d));
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        cmp("lanes_active", 4, lanes_active);
        cmp("frames_per_multiframe", 32, frames_per_multiframe);
        cmp("octets_per_frame", 1, octets_per_frame);
        cmp("scrambler_en", 1, scrambler_en);
        for (i = 0; i < 11; i++)
            rd(ra[i], rv[i]);
        rd(12'h0582, 8'h00);
        for (i = 0; i < 11; i++)
        begin
            wv[i] = 8'($urandom);
            wr(ra[i], wv[i]);
            rd(ra[i], wv[i] & rm[i]);
        end
        settle();
        cmp("device_id", wv[2], device_id);
        cmp("bank_id", wv[3][3:0], bank_id);
        for (i = 0; i < 4; i++)
            cmp("lane_id", wv[4 + i][4:0], lane_id[i]);
        cmp("scrambler_en", wv[8][7], scrambler_en);
        cmp("lane_count_code", wv[8][4:0], lane_count_code);
        for (i = 0; i < 8; i++)
        begin
            wr(`A_LL_TEST, 8'(i));
            settle();
            cmp("test_mode", i, test_mode);
            cmp("test_active", (i == 1 || (i >= 4 && i <= 6)), test_active);
            cmp("test_octet", (i == 1) ? 8'hb5 : 8'h00, test_octet);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(`A_SCR_LANES, {1'($urandom), 2'b00, 5'(lc[i])});
            settle();
            cmp("lanes_active", la[i], lanes_active);
        end
        for (i = 0; i < 7; i++)
        begin
            f = fc[i];
            k = $urandom % 32;
            wr(`A_OCT_FRAME, 8'(f));
            wr(`A_FRM_MF, 8'(k));
            settle();
            cmp("octets_per_frame", f + 1, octets_per_frame);
            cmp("frames_per_multiframe", k + 1, frames_per_multiframe);
            cmp("cfg_invalid", ((f + 1) * (k + 1)) % 4 != 0, cfg_invalid);
        end
        wr(`A_FRM_MF, 8'h07);
        off = $urandom % 6;
        wr(`A_PHASE_OFS, 8'(off));
        fork
            link_rx_model_i.fire_sysref(7);
            begin
                // two sync stages, then the load edge
                repeat (4) @(posedge ref_clk);
                @(negedge ref_clk);
                cmp("mf_phase", off, mf_phase);
                repeat (2) @(posedge ref_clk);
                @(negedge ref_clk);
                cmp("mf_phase", off + 2, mf_phase);
                rd(`A_STATUS, {3'h0, 5'((off + 3) % 8)});
            end
        join
        n0 = mf_count;
        for (i = 0; i < 100 && mf_count < n0 + 2; i++)
            @(posedge ref_clk);
        @(negedge ref_clk);
        cmp("mf_period", 8, mf_period);
        cmp("mf_count", n0 + 2, mf_count);
        // a one-cycle pulse must still reload the phase exactly once
        link_rx_model_i.fire_sysref(1);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp("mf_phase", off, mf_phase);
        repeat (3) @(posedge ref_clk);
        close_out();
    end
endmodule
